// >>> logic/bcd_clock_calendar.sv
// BCD clock/calendar with APB register access and a program load port
// Assumes APB master on clk; setters supply valid BCD fields; backup monitor drives backup_expired
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module bcd_clock_calendar #(
	parameter int TICK_COUNT = clock_calendar_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Calendar load instruction from the user program
	input wire logic calendar_load_instruction,
	input wire logic [7:0] load_year,
	input wire logic [7:0] load_month,
	input wire logic [7:0] load_day,
	input wire logic [7:0] load_hour,
	input wire logic [7:0] load_minute,
	input wire logic [7:0] load_second,
	// Power and backup monitor
	input wire logic main_power_on,
	input wire logic backup_expired,
	// Special register outputs
	output logic [15:0] year_reg,
	output logic [15:0] month_reg,
	output logic [15:0] day_reg,
	output logic [15:0] hour_reg,
	output logic [15:0] minute_reg,
	output logic [15:0] second_reg,
	output logic [15:0] weekday_reg,
	output logic time_invalid_flag,
	// Interrupt
	output logic irq
);
	import clock_calendar_pkg::*;

	logic [7:0] year, month, day, hour, minute, second;
	logic [2:0] weekday;
	logic [7:0] set_year, set_month, set_day, set_hour, set_minute, set_second;
	logic [31:0] tick_count;
	logic [IRQ_WIDTH-1:0] irq_status, irq_mask, rd_clear;
	logic [31:0] rd_data;
	logic rd_err;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic int bcd_bin(input logic [7:0] v);
		bcd_bin = int'(v[7:4]) * 10 + int'(v[3:0]);
	endfunction

	function automatic logic [2:0] weekday_of(input logic [7:0] y, input logic [7:0] m, input logic [7:0] d);
		int yr;
		int mo;
		int t;
		yr = CENTURY_BASE + bcd_bin(y);
		mo = bcd_bin(m);
		if (mo < 3)
		begin
			yr = yr - 1;
		end
		case (mo)
			2: t = 3;
			3: t = 2;
			4: t = 5;
			5: t = 0;
			6: t = 3;
			7: t = 5;
			8: t = 1;
			9: t = 4;
			10: t = 6;
			11: t = 2;
			12: t = 4;
			default: t = 0;
		endcase
		weekday_of = 3'((yr + yr / 4 - yr / 100 + yr / 400 + t + bcd_bin(d)) % 7);
	endfunction

	// APB decode
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire wr_en = access && pwrite;
	wire rd_done = access && !pwrite;
	wire hit_ro = (paddr <= OFS_WEEKDAY) && (paddr[1:0] == 2'b00);
	wire hit_set = (paddr >= OFS_SET_YEAR) && (paddr <= OFS_SET_SECOND) && (paddr[1:0] == 2'b00);
	wire hit_ctl = (paddr >= OFS_CTRL) && (paddr <= OFS_IRQ_MASK) && (paddr[1:0] == 2'b00);
	wire mapped = hit_ro || hit_set || hit_ctl;
	wire bus_load = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_LOAD_BIT];

	// Timebase
	wire tick = (tick_count == 32'(TICK_COUNT - 1));

	// Load source selection, instruction first
	wire load = calendar_load_instruction || bus_load;
	wire [7:0] ld_year = calendar_load_instruction ? load_year : set_year;
	wire [7:0] ld_month = calendar_load_instruction ? load_month : set_month;
	wire [7:0] ld_day = calendar_load_instruction ? load_day : set_day;
	wire [7:0] ld_hour = calendar_load_instruction ? load_hour : set_hour;
	wire [7:0] ld_minute = calendar_load_instruction ? load_minute : set_minute;
	wire [7:0] ld_second = calendar_load_instruction ? load_second : set_second;
	wire [2:0] ld_weekday = weekday_of(ld_year, ld_month, ld_day);

	// Month length with leap years, valid for 2000 to 2099
	wire leap = (bcd_bin(year) % 4) == 0;
	wire long30 = (month == 8'h04) || (month == 8'h06) || (month == 8'h09) || (month == 8'h11);
	wire [7:0] days_in_month = (month == BCD_FEB) ? (leap ? BCD_DAYS_29 : BCD_DAYS_28) :
		(long30 ? BCD_DAYS_30 : BCD_DAYS_31);

	// Carry chain
	wire sec_wrap = tick && (second == BCD_MAX_MINSEC);
	wire min_wrap = sec_wrap && (minute == BCD_MAX_MINSEC);
	wire hour_wrap = min_wrap && (hour == BCD_MAX_HOUR);
	wire day_wrap = hour_wrap && (day == days_in_month);
	wire month_wrap = day_wrap && (month == BCD_MAX_MONTH);
	wire [7:0] next_second = sec_wrap ? BCD_ZERO : bcd_inc(second);
	wire [7:0] next_minute = min_wrap ? BCD_ZERO : bcd_inc(minute);
	wire [7:0] next_hour = hour_wrap ? BCD_ZERO : bcd_inc(hour);
	wire [7:0] next_day = day_wrap ? BCD_ONE : bcd_inc(day);
	wire [7:0] next_month = month_wrap ? BCD_ONE : bcd_inc(month);
	wire [7:0] next_year = (year == BCD_MAX_YEAR) ? BCD_ZERO : bcd_inc(year);
	wire [2:0] next_weekday = (weekday == WEEKDAY_MAX) ? 3'h0 : weekday + 3'h1;

	// Events
	wire invalid_event = backup_expired && !time_invalid_flag;
	wire [IRQ_WIDTH-1:0] irq_set = {load, invalid_event, tick};

	// Read data select
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_err = !mapped;
		rd_clear = '0;
		unique case (paddr)
			OFS_YEAR: rd_data = {24'h00_0000, year};
			OFS_MONTH: rd_data = {24'h00_0000, month};
			OFS_DAY: rd_data = {24'h00_0000, day};
			OFS_HOUR: rd_data = {24'h00_0000, hour};
			OFS_MINUTE: rd_data = {24'h00_0000, minute};
			OFS_SECOND: rd_data = {24'h00_0000, second};
			OFS_WEEKDAY: rd_data = {29'h0000_0000, weekday};
			OFS_SET_YEAR: rd_data = {24'h00_0000, set_year};
			OFS_SET_MONTH: rd_data = {24'h00_0000, set_month};
			OFS_SET_DAY: rd_data = {24'h00_0000, set_day};
			OFS_SET_HOUR: rd_data = {24'h00_0000, set_hour};
			OFS_SET_MINUTE: rd_data = {24'h00_0000, set_minute};
			OFS_SET_SECOND: rd_data = {24'h00_0000, set_second};
			OFS_STATUS: rd_data = {30'h0000_0000, main_power_on, time_invalid_flag};
			OFS_IRQ_STATUS:
			begin
				rd_data = {29'h0000_0000, irq_status};
				rd_clear = irq_status;
			end
			OFS_IRQ_MASK: rd_data = {29'h0000_0000, irq_mask};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// APB answer: data captured in setup, ready in access
	logic [IRQ_WIDTH-1:0] clear_hold;
	assign pready = 1'b1;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			clear_hold <= '0;
		end
		else if (setup)
		begin
			prdata <= pwrite ? 32'h0000_0000 : rd_data;
			pslverr <= rd_err;
			clear_hold <= pwrite ? '0 : rd_clear;
		end
	end

	// Setting staging registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			set_year <= RST_YEAR;
			set_month <= RST_MONTH;
			set_day <= RST_DAY;
			set_hour <= RST_HMS;
			set_minute <= RST_HMS;
			set_second <= RST_HMS;
			irq_mask <= '0;
		end
		else if (wr_en)
		begin
			if (paddr == OFS_SET_YEAR) set_year <= pwdata[7:0];
			if (paddr == OFS_SET_MONTH) set_month <= pwdata[7:0];
			if (paddr == OFS_SET_DAY) set_day <= pwdata[7:0];
			if (paddr == OFS_SET_HOUR) set_hour <= pwdata[7:0];
			if (paddr == OFS_SET_MINUTE) set_minute <= pwdata[7:0];
			if (paddr == OFS_SET_SECOND) set_second <= pwdata[7:0];
			if (paddr == OFS_IRQ_MASK) irq_mask <= pwdata[IRQ_WIDTH-1:0];
		end
	end

	// Timebase, restarted by a load
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tick_count <= 32'h0000_0000;
		else if (load || tick)
			tick_count <= 32'h0000_0000;
		else
			tick_count <= tick_count + 32'h0000_0001;
	end

	// Calendar counters, never gated by main power
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			year <= RST_YEAR;
			month <= RST_MONTH;
			day <= RST_DAY;
			hour <= RST_HMS;
			minute <= RST_HMS;
			second <= RST_HMS;
			weekday <= RST_WEEKDAY;
		end
		else if (load)
		begin
			year <= ld_year;
			month <= ld_month;
			day <= ld_day;
			hour <= ld_hour;
			minute <= ld_minute;
			second <= ld_second;
			weekday <= ld_weekday;
		end
		else if (tick)
		begin
			second <= next_second;
			if (sec_wrap) minute <= next_minute;
			if (min_wrap) hour <= next_hour;
			if (hour_wrap) day <= next_day;
			if (hour_wrap) weekday <= next_weekday;
			if (day_wrap) month <= next_month;
			if (month_wrap) year <= next_year;
		end
	end

	// Invalid flag: expiry wins over a load in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			time_invalid_flag <= RST_INVALID;
		else if (backup_expired)
			time_invalid_flag <= 1'b1;
		else if (load)
			time_invalid_flag <= 1'b0;
	end

	// Sticky interrupt status, set wins over read clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_status <= '0;
		else
			irq_status <= (irq_status & ~(rd_done ? clear_hold : '0)) | irq_set;
	end
	assign irq = |(irq_status & irq_mask);

	// Special register views
	assign year_reg = {8'h00, year};
	assign month_reg = {8'h00, month};
	assign day_reg = {8'h00, day};
	assign hour_reg = {8'h00, hour};
	assign minute_reg = {8'h00, minute};
	assign second_reg = {8'h00, second};
	assign weekday_reg = {13'h0000, weekday};

	// Checks
	AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_n) prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	AST_YEAR_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
		(!load && month_wrap && year == BCD_MAX_YEAR) |=> year == BCD_ZERO)
		else $error("year did not roll to 00");
	AST_MONTH_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
		!load |=> (month >= BCD_ONE && month <= BCD_MAX_MONTH))
		else $error("month out of range");
	AST_DAY_ROLL: assert property (@(posedge clk) disable iff (!rst_n)
		(!load && hour_wrap && day == days_in_month) |=> day == BCD_ONE && month != $past(month))
		else $error("day did not roll into next month");
	AST_HOUR_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
		(!load && hour_wrap) |=> hour == BCD_ZERO && day != $past(day))
		else $error("hour did not wrap");
	AST_MINUTE_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
		(!load && sec_wrap && minute != BCD_MAX_MINSEC) |=> second == BCD_ZERO && minute == bcd_inc($past(minute)))
		else $error("minute carry wrong");
	AST_WEEKDAY_RANGE: assert property (@(posedge clk) disable iff (!rst_n) weekday <= WEEKDAY_MAX)
		else $error("weekday out of range");
	AST_POWER_COUNTS: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && !load && !main_power_on) |=> second != $past(second))
		else $error("clock stopped without main power");
	AST_INVALID_SET: assert property (@(posedge clk) disable iff (!rst_n)
		backup_expired |=> time_invalid_flag ##1 (time_invalid_flag || $past(load)))
		else $error("invalid flag not set on expiry");
	AST_LOAD_WEEKDAY: assert property (@(posedge clk) disable iff (!rst_n)
		load |=> weekday == $past(ld_weekday) && day == $past(ld_day))
		else $error("weekday not computed on load");
	AST_LOAD_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
		(load && !backup_expired) |=> !time_invalid_flag && tick_count == 32'h0000_0000)
		else $error("load did not clear flag or restart timebase");
	COV_YEAR_WRAP: cover property (@(posedge clk) disable iff (!rst_n) month_wrap && year == BCD_MAX_YEAR);
	COV_LEAP_DAY: cover property (@(posedge clk) disable iff (!rst_n) month == BCD_FEB && day == BCD_DAYS_29);
	COV_INSTR_LOAD: cover property (@(posedge clk) disable iff (!rst_n) calendar_load_instruction);
	COV_BUS_LOAD: cover property (@(posedge clk) disable iff (!rst_n) bus_load && !calendar_load_instruction);
	COV_IRQ: cover property (@(posedge clk) disable iff (!rst_n) irq && invalid_event);
endmodule // bcd_clock_calendar

// >>> shared/clock_calendar_pkg.sv
// Constants for the BCD clock/calendar block
// Assumes a 40 MHz clock and a 32-bit APB register bus
package clock_calendar_pkg;
	// Clock and timebase
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_PERIOD_S = 1;
	localparam int TICK_CYCLES = TICK_PERIOD_S * CLK_HZ;
	// Register byte offsets
	localparam logic [7:0] OFS_YEAR = 8'h00;
	localparam logic [7:0] OFS_MONTH = 8'h04;
	localparam logic [7:0] OFS_DAY = 8'h08;
	localparam logic [7:0] OFS_HOUR = 8'h0C;
	localparam logic [7:0] OFS_MINUTE = 8'h10;
	localparam logic [7:0] OFS_SECOND = 8'h14;
	localparam logic [7:0] OFS_WEEKDAY = 8'h18;
	localparam logic [7:0] OFS_SET_YEAR = 8'h20;
	localparam logic [7:0] OFS_SET_MONTH = 8'h24;
	localparam logic [7:0] OFS_SET_DAY = 8'h28;
	localparam logic [7:0] OFS_SET_HOUR = 8'h2C;
	localparam logic [7:0] OFS_SET_MINUTE = 8'h30;
	localparam logic [7:0] OFS_SET_SECOND = 8'h34;
	localparam logic [7:0] OFS_CTRL = 8'h40;
	localparam logic [7:0] OFS_STATUS = 8'h44;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h48;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h4C;
	// Field positions
	localparam int CTRL_LOAD_BIT = 0;
	localparam int STATUS_INVALID_BIT = 0;
	localparam int STATUS_POWER_BIT = 1;
	localparam int IRQ_TICK_BIT = 0;
	localparam int IRQ_INVALID_BIT = 1;
	localparam int IRQ_LOAD_BIT = 2;
	localparam int IRQ_WIDTH = 3;
	// BCD limits
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	localparam logic [7:0] BCD_MAX_YEAR = 8'h99;
	localparam logic [7:0] BCD_MAX_MONTH = 8'h12;
	localparam logic [7:0] BCD_MAX_HOUR = 8'h23;
	localparam logic [7:0] BCD_MAX_MINSEC = 8'h59;
	localparam logic [7:0] BCD_FEB = 8'h02;
	localparam logic [7:0] BCD_DAYS_31 = 8'h31;
	localparam logic [7:0] BCD_DAYS_30 = 8'h30;
	localparam logic [7:0] BCD_DAYS_29 = 8'h29;
	localparam logic [7:0] BCD_DAYS_28 = 8'h28;
	localparam logic [2:0] WEEKDAY_MAX = 3'h6;
	localparam int CENTURY_BASE = 2000;
	// Reset values: 2000-01-01 00:00:00, a Saturday, flagged invalid
	localparam logic [7:0] RST_YEAR = 8'h00;
	localparam logic [7:0] RST_MONTH = 8'h01;
	localparam logic [7:0] RST_DAY = 8'h01;
	localparam logic [7:0] RST_HMS = 8'h00;
	localparam logic [2:0] RST_WEEKDAY = 3'h6;
	localparam logic RST_INVALID = 1'b1;
endpackage

// >>> testbench/bcd_clock_calendar_tb.sv
// Self-checking bench for the BCD clock/calendar block
// Assumes the block's own assertions run alongside; a short tick period keeps the run brief
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module bcd_clock_calendar_tb;
	import clock_calendar_pkg::*;
	localparam int TICK = 8;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic calendar_load_instruction = 1'b0, main_power_on = 1'b1, backup_expired = 1'b0;
	logic [7:0] load_year = 8'h00, load_month = 8'h01, load_day = 8'h01;
	logic [7:0] load_hour = 8'h00, load_minute = 8'h00, load_second = 8'h00;
	logic [15:0] year_reg, month_reg, day_reg, hour_reg, minute_reg, second_reg, weekday_reg;
	logic time_invalid_flag, irq;
	int error_cnt = 0, total_checks = 0, cycles = 0;

	bcd_clock_calendar #(.TICK_COUNT(TICK)) i_bcd_clock_calendar (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.calendar_load_instruction(calendar_load_instruction), .load_year(load_year),
		.load_month(load_month), .load_day(load_day), .load_hour(load_hour), .load_minute(load_minute),
		.load_second(load_second), .main_power_on(main_power_on), .backup_expired(backup_expired),
		.year_reg(year_reg), .month_reg(month_reg), .day_reg(day_reg), .hour_reg(hour_reg),
		.minute_reg(minute_reg), .second_reg(second_reg), .weekday_reg(weekday_reg),
		.time_invalid_flag(time_invalid_flag), .irq(irq));

	always #12.5 clk = ~clk;

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One APB transfer: setup, access until pready, then release
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		`CHK("pready", 1'b1, pready)
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] ex, input logic eex);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		`CHK("prdata", ex, r)
		`CHK("pslverr", eex, e)
	endtask

	// Load pulse on the instruction port; returns once the new values have landed
	task automatic load(input logic [7:0] y, mo, d, h, mi, s);
		@(posedge clk);
		calendar_load_instruction <= 1'b1;
		load_year <= y;
		load_month <= mo;
		load_day <= d;
		load_hour <= h;
		load_minute <= mi;
		load_second <= s;
		@(posedge clk);
		calendar_load_instruction <= 1'b0;
		#1;
	endtask

	task automatic wait_tick;
		logic [15:0] s0;
		int n;
		s0 = second_reg;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (second_reg === s0 && n < 3 * TICK);
		`CHK("tick seen", 1'b1, second_reg !== s0)
	endtask

	task automatic chk_time(input logic [7:0] y, mo, d, input logic [2:0] w, input logic [7:0] h, mi, s);
		`CHK("year", {8'h00, y}, year_reg)
		`CHK("month", {8'h00, mo}, month_reg)
		`CHK("day", {8'h00, d}, day_reg)
		`CHK("weekday", {13'h0000, w}, weekday_reg)
		`CHK("hour", {8'h00, h}, hour_reg)
		`CHK("minute", {8'h00, mi}, minute_reg)
		`CHK("second", {8'h00, s}, second_reg)
	endtask

	task automatic t_reset;
		chk_time(RST_YEAR, RST_MONTH, RST_DAY, RST_WEEKDAY, RST_HMS, RST_HMS, RST_HMS);
		`CHK("invalid after reset", 1'b1, time_invalid_flag)
		`CHK("irq after reset", 1'b0, irq)
	endtask

	// Leap day reached from 28 Feb 2024, a Wednesday
	task automatic t_leap;
		load(8'h24, 8'h02, 8'h28, 8'h23, 8'h59, 8'h59);
		`CHK("weekday on load", 16'h0003, weekday_reg)
		wait_tick();
		chk_time(8'h24, 8'h02, 8'h29, 3'h4, 8'h00, 8'h00, 8'h00);
	endtask

	task automatic t_month_ends;
		logic [7:0] cy[5] = '{8'h23, 8'h24, 8'h24, 8'h24, 8'h24};
		logic [7:0] cm[5] = '{8'h02, 8'h02, 8'h04, 8'h01, 8'h12};
		logic [7:0] cd[5] = '{8'h28, 8'h29, 8'h30, 8'h31, 8'h31};
		logic [7:0] ey[5] = '{8'h23, 8'h24, 8'h24, 8'h24, 8'h25};
		logic [7:0] em[5] = '{8'h03, 8'h03, 8'h05, 8'h02, 8'h01};
		for (int i = 0; i < 5; i++)
		begin
			load(cy[i], cm[i], cd[i], 8'h23, 8'h59, 8'h59);
			wait_tick();
			`CHK("carry year", {8'h00, ey[i]}, year_reg)
			`CHK("carry month", {8'h00, em[i]}, month_reg)
			`CHK("carry day", 16'h0001, day_reg)
			`CHK("carry hour", 16'h0000, hour_reg)
		end
	endtask

	// Bus path load of 31 Dec 2099, a Thursday, then the century roll
	task automatic t_bus_load;
		wr(OFS_SET_YEAR, 32'h99);
		wr(OFS_SET_MONTH, 32'h12);
		wr(OFS_SET_DAY, 32'h31);
		wr(OFS_SET_HOUR, 32'h23);
		wr(OFS_SET_MINUTE, 32'h59);
		wr(OFS_SET_SECOND, 32'h58);
		rdchk(OFS_SET_SECOND, 32'h00000058, 1'b0);
		wr(OFS_CTRL, 32'h1);
		@(posedge clk);
		#1;
		`CHK("bus weekday", 16'h0004, weekday_reg)
		rdchk(OFS_YEAR, 32'h00000099, 1'b0);
		rdchk(OFS_WEEKDAY, 32'h00000004, 1'b0);
		wait_tick();
		wait_tick();
		`CHK("century year", 16'h0000, year_reg)
		`CHK("century month", 16'h0001, month_reg)
		wr(OFS_YEAR, 32'h55);
		rdchk(OFS_YEAR, 32'h00000000, 1'b0);
	endtask

	task automatic t_restart;
		load(8'h24, 8'h06, 8'h15, 8'h10, 8'h20, 8'h30);
		repeat (TICK - 1) @(posedge clk);
		#1;
		`CHK("second held", 16'h0030, second_reg)
		@(posedge clk);
		#1;
		`CHK("second stepped", 16'h0031, second_reg)
	endtask

	task automatic t_invalid;
		@(posedge clk);
		main_power_on <= 1'b0;
		backup_expired <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK("invalid set", 1'b1, time_invalid_flag)
		rdchk(OFS_STATUS, 32'h00000001, 1'b0);
		load(8'h24, 8'h03, 8'h10, 8'h08, 8'h00, 8'h00);
		`CHK("invalid beats load", 1'b1, time_invalid_flag)
		@(posedge clk);
		backup_expired <= 1'b0;
		load(8'h24, 8'h03, 8'h10, 8'h08, 8'h00, 8'h00);
		`CHK("invalid cleared", 1'b0, time_invalid_flag)
		wait_tick();
		`CHK("runs on backup", 16'h0001, second_reg)
		@(posedge clk);
		main_power_on <= 1'b1;
		rdchk(OFS_STATUS, 32'h00000002, 1'b0);
	endtask

	task automatic t_irq;
		logic [31:0] r;
		logic e;
		wr(OFS_IRQ_MASK, 32'h0);
		load(8'h24, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00);
		`CHK("irq masked", 1'b0, irq)
		apb(1'b0, OFS_IRQ_STATUS, 32'h0, r, e);
		`CHK("load event", 1'b1, r[IRQ_LOAD_BIT])
		`CHK("tick event", 1'b1, r[IRQ_TICK_BIT])
		`CHK("invalid event", 1'b1, r[IRQ_INVALID_BIT])
		wr(OFS_IRQ_MASK, 32'h4);
		rdchk(OFS_IRQ_MASK, 32'h00000004, 1'b0);
		#1;
		`CHK("irq idle", 1'b0, irq)
		load(8'h24, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00);
		`CHK("irq raised", 1'b1, irq)
		apb(1'b0, OFS_IRQ_STATUS, 32'h0, r, e);
		#1;
		`CHK("irq cleared", 1'b0, irq)
	endtask

	task automatic t_unmapped;
		rdchk(8'h50, 32'h0, 1'b1);
		rdchk(8'h02, 32'h0, 1'b1);
		rdchk(OFS_CTRL, 32'h0, 1'b0);
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_leap();
		t_month_ends();
		t_bus_load();
		t_restart();
		t_invalid();
		t_irq();
		t_unmapped();
		finish_test();
	end
endmodule // bcd_clock_calendar_tb
